// ---- qdu_pkg.sv ----
// quad dac update control: shared constants, types and helpers
// assumes sys_clk at 20 MHz and one controller on the two-wire link
//
// Functional notes
// - device is target only, never drives clock
// - sample data on rise, change on fall
// - data stable while clock high
// - strobe falling edge updates all four outputs
// - strobe held low: update at last ack
// - update bit touches selected channel only
// - strobe selects device for address rewrite
// - busy pin low while nvm programs
// - power-down picks one of three loads
// - output gain one or two per channel
// - power-up loads nvm into both registers
// - writes change input registers only
// - outputs follow only when strobe/update low
// - four channels, twelve-bit codes each
// - address, config and codes storable in nvm
// - power-down codes: normal, 1k, 100k, 500k
// - supply reference forces unity gain
// - update bit 0 uploads, 1 holds
// - general call reset reloads like power-up
`default_nettype none

package qdu_pkg;
  // timing
  localparam int SYS_CLK_NS = 50;
  localparam int SCL_PERIOD_NS = 400;
  localparam int SCL_QTR_RAW = SCL_PERIOD_NS / (4 * SYS_CLK_NS);
  localparam int SCL_QTR_CYCLES = (SCL_QTR_RAW < 1) ? 1 : SCL_QTR_RAW;
  localparam int NVM_PROG_US = 50;
  localparam int NVM_PROG_CYCLES = (NVM_PROG_US * 1000) / SYS_CLK_NS;
  // channel word: ref, power-down, gain, code
  localparam int NUM_CH = 4;
  localparam int CODE_W = 12;
  localparam int W_VREF = 15;
  localparam int W_PD_LSB = 13;
  localparam int W_GAIN = 12;
  localparam logic [15:0] NVM_WORD_RST = 16'h8000;
  localparam logic [2:0] NVM_ADDR_RST = 3'h0;
  // powerdown_select encodings
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_500K = 2'h3;
  // link bytes
  localparam logic [3:0] ADDR_PREFIX = 4'hc;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_STORE = 3'h3;
  localparam logic [2:0] CMD_ADDR = 3'h4;
  // controller register offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STROBE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_CH_LSB = 3;
  localparam int CTRL_UPD = 5;
  localparam int CTRL_TGT_LSB = 8;
  localparam int CTRL_NEW_LSB = 12;
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_STORE = 3'h1;
  localparam logic [2:0] OP_GCRESET = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_ADDR = 3'h4;

  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_WAIT} qdu_tgt_state_t;
  typedef enum logic [1:0] {HST_IDLE, HST_START, HST_BIT, HST_STOP} qdu_hst_state_t;

  // address byte: fixed prefix, three address bits, direction
  function automatic logic [7:0] qdu_addr_byte(input logic [2:0] a, input logic rw);
    return {ADDR_PREFIX, a, rw};
  endfunction: qdu_addr_byte

  // gain of two only with internal reference
  function automatic logic qdu_gain2(input logic [15:0] w);
    return w[W_VREF] & w[W_GAIN];
  endfunction: qdu_gain2
endpackage: qdu_pkg

`default_nettype wire

// ---- qdu_link_if.sv ----
// quad dac update control: link between controller and converter
// assumes pull-ups on both wires and on the busy line
`default_nettype none

interface qdu_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_hst_o;
  logic sda_hst_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic output_load_strobe_n;
  logic nvm_ready_busy_n_o;
  logic nvm_ready_busy_n_oe_n;
  logic scl;
  logic sda;
  logic nvm_ready_busy_n;

  // wired levels with pull-ups
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_hst_oe_n | sda_hst_o) & (sda_dev_oe_n | sda_dev_o);
  assign nvm_ready_busy_n = nvm_ready_busy_n_oe_n | nvm_ready_busy_n_o;

  modport dev (
    input scl,
    input sda,
    input output_load_strobe_n,
    output sda_dev_o,
    output sda_dev_oe_n,
    output nvm_ready_busy_n_o,
    output nvm_ready_busy_n_oe_n
  );
  modport hst (
    output scl_o,
    output scl_oe_n,
    output sda_hst_o,
    output sda_hst_oe_n,
    output output_load_strobe_n,
    input scl,
    input sda,
    input nvm_ready_busy_n
  );
endinterface: qdu_link_if

`default_nettype wire

// ---- qdu_dev.sv ----
// quad dac update control: converter end of the link
// assumes a controller that owns the clock wire and the load strobe
//
// The implementer's own choices: the register addresses and the strobed register port.
`default_nettype none

module qdu_dev #(
  parameter int unsigned PROG_CYCLES = qdu_pkg::NVM_PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  qdu_link_if.dev link,
  output logic [3:0][11:0] dac_code,
  output logic [3:0][1:0] powerdown_select,
  output logic [3:0] gain_x2,
  output logic nvm_busy
);
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] ld_sy;
    logic scl_d;
    logic sda_d;
    logic ld_d;
    qdu_pkg::qdu_tgt_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic gcall;
    logic rd;
    logic [2:0] cmd;
    logic [1:0] ch;
    logic upd_n;
    logic [7:0] hi;
    logic [3:0][15:0] in_word;
    logic [3:0][15:0] nvm_word;
    logic [2:0] addr_bits;
    logic [2:0] nvm_addr;
    logic store_pend;
    logic [15:0] busy_cnt;
    logic sda_oe_n;
    logic rdy_oe_n;
    logic [3:0][11:0] code;
    logic [3:0][1:0] pd;
    logic [3:0] g2;
  } qdu_dev_st_t;

  qdu_dev_st_t st_ff;
  qdu_dev_st_t nxt_st;
  logic scl_hi;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic ld_fall;

  // copy one channel word into the output register
  function automatic qdu_dev_st_t upload(input qdu_dev_st_t s, input logic [1:0] c,
                                         input logic [15:0] w);
    qdu_dev_st_t r;
    r = s;
    r.code[c] = w[11:0];
    r.pd[c] = w[qdu_pkg::W_PD_LSB +: 2];
    r.g2[c] = qdu_pkg::qdu_gain2(w);
    return r;
  endfunction: upload

  ////////////////////////////////////////////////////////////////////////
  // edge and condition detection on synchronised pins
  assign scl_hi = st_ff.scl_sy[1];
  assign scl_rise = scl_hi & ~st_ff.scl_d;
  assign scl_fall = ~scl_hi & st_ff.scl_d;
  assign start_c = scl_hi & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_sy[1];
  assign stop_c = scl_hi & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_sy[1];
  assign ld_fall = st_ff.ld_d & ~st_ff.ld_sy[1];

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [15:0] w;
    logic ack;
    w = '0;
    ack = 1'h0;
    nxt_st = st_ff;
    nxt_st.scl_sy = {st_ff.scl_sy[0], link.scl};
    nxt_st.sda_sy = {st_ff.sda_sy[0], link.sda};
    nxt_st.ld_sy = {st_ff.ld_sy[0], link.output_load_strobe_n};
    nxt_st.scl_d = st_ff.scl_sy[1];
    nxt_st.sda_d = st_ff.sda_sy[1];
    nxt_st.ld_d = st_ff.ld_sy[1];
    // nvm programming timer, busy line released at the end
    if (st_ff.busy_cnt != 16'h0) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - 16'h1;
      if (st_ff.busy_cnt == 16'h1) begin
        nxt_st.rdy_oe_n = 1'h1;
      end
    end
    if (start_c) begin
      nxt_st.state = qdu_pkg::I2C_RX;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.byte_idx = 2'h0;
      nxt_st.sda_oe_n = 1'h1;
    end else if (stop_c) begin
      nxt_st.state = qdu_pkg::I2C_IDLE;
      nxt_st.sda_oe_n = 1'h1;
      if (st_ff.store_pend) begin
        nxt_st.store_pend = 1'h0;
        nxt_st.busy_cnt = PROG_CYCLES[15:0];
        nxt_st.rdy_oe_n = 1'h0;
      end
    end else begin
      unique case (st_ff.state)
        qdu_pkg::I2C_RX: begin
          if (scl_rise && st_ff.bit_cnt != 4'h8) begin
            nxt_st.shift = {st_ff.shift[6:0], st_ff.sda_sy[1]};
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
            unique case (st_ff.byte_idx)
              2'h0: begin
                nxt_st.gcall = st_ff.shift == qdu_pkg::GC_ADDR;
                ack = nxt_st.gcall ||
                      st_ff.shift[7:1] == {qdu_pkg::ADDR_PREFIX, st_ff.addr_bits};
                nxt_st.rd = st_ff.shift[0] & ~nxt_st.gcall;
                nxt_st.byte_idx = 2'h1;
              end
              2'h1: begin
                if (st_ff.gcall) begin
                  ack = st_ff.shift == qdu_pkg::GC_RESET;
                  if (ack) begin
                    nxt_st.in_word = st_ff.nvm_word;
                    nxt_st.addr_bits = st_ff.nvm_addr;
                    for (int i = 0; i < qdu_pkg::NUM_CH; i++) begin
                      nxt_st = upload(nxt_st, 2'(i), st_ff.nvm_word[i]);
                    end
                  end
                end else if (st_ff.shift[7:5] == qdu_pkg::CMD_ADDR) begin
                  ack = ~st_ff.ld_sy[1] & st_ff.rdy_oe_n;
                  if (ack) begin
                    nxt_st.addr_bits = st_ff.shift[4:2];
                    nxt_st.nvm_addr = st_ff.shift[4:2];
                    nxt_st.store_pend = 1'h1;
                  end
                end else begin
                  nxt_st.cmd = st_ff.shift[7:5];
                  nxt_st.ch = st_ff.shift[2:1];
                  nxt_st.upd_n = st_ff.shift[0];
                  nxt_st.byte_idx = 2'h2;
                  ack = (st_ff.shift[7:5] == qdu_pkg::CMD_WRITE) ||
                        (st_ff.shift[7:5] == qdu_pkg::CMD_STORE && st_ff.rdy_oe_n);
                end
              end
              2'h2: begin
                nxt_st.hi = st_ff.shift;
                nxt_st.byte_idx = 2'h3;
                ack = 1'h1;
              end
              2'h3: begin
                w = {st_ff.hi, st_ff.shift};
                nxt_st.in_word[st_ff.ch] = w;
                // held-low strobe or cleared update bit
                if (!st_ff.ld_sy[1] || !st_ff.upd_n) begin
                  nxt_st = upload(nxt_st, st_ff.ch, w);
                end
                if (st_ff.cmd == qdu_pkg::CMD_STORE) begin
                  nxt_st.nvm_word[st_ff.ch] = w;
                  nxt_st.store_pend = 1'h1;
                end
                nxt_st.byte_idx = 2'h1;
                ack = 1'h1;
              end
            endcase
            nxt_st.sda_oe_n = ~ack;
            nxt_st.state = ack ? qdu_pkg::I2C_ACK : qdu_pkg::I2C_WAIT;
          end
        end
        qdu_pkg::I2C_ACK: begin
          if (scl_fall) begin
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sda_oe_n = 1'h1;
            nxt_st.state = qdu_pkg::I2C_RX;
            if (st_ff.rd) begin
              // status byte: ready flag, address bits
              w = {8'h00, st_ff.rdy_oe_n, st_ff.addr_bits, 4'h0};
              nxt_st.sda_oe_n = w[7];
              nxt_st.shift = {w[6:0], 1'h0};
              nxt_st.bit_cnt = 4'h1;
              nxt_st.state = qdu_pkg::I2C_TX;
            end
          end
        end
        qdu_pkg::I2C_TX: begin
          if (scl_fall) begin
            if (st_ff.bit_cnt == 4'h8) begin
              nxt_st.sda_oe_n = 1'h1;
              nxt_st.state = qdu_pkg::I2C_WAIT;
            end else begin
              nxt_st.sda_oe_n = st_ff.shift[7];
              nxt_st.shift = {st_ff.shift[6:0], 1'h0};
              nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
            end
          end
        end
        qdu_pkg::I2C_IDLE, qdu_pkg::I2C_WAIT: begin
          nxt_st.sda_oe_n = 1'h1;
        end
        default: begin
          nxt_st.state = qdu_pkg::I2C_IDLE;
        end
      endcase
    end
    // strobe edge copies every input register, after any write above
    if (ld_fall) begin
      for (int i = 0; i < qdu_pkg::NUM_CH; i++) begin
        nxt_st = upload(nxt_st, 2'(i), nxt_st.in_word[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, power-up image is the nvm contents
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.scl_sy <= 2'h3;
      st_ff.sda_sy <= 2'h3;
      st_ff.ld_sy <= 2'h3;
      st_ff.scl_d <= 1'h1;
      st_ff.sda_d <= 1'h1;
      st_ff.ld_d <= 1'h1;
      st_ff.state <= qdu_pkg::I2C_IDLE;
      st_ff.sda_oe_n <= 1'h1;
      st_ff.rdy_oe_n <= 1'h1;
      st_ff.in_word <= {4{qdu_pkg::NVM_WORD_RST}};
      st_ff.nvm_word <= {4{qdu_pkg::NVM_WORD_RST}};
      st_ff.addr_bits <= qdu_pkg::NVM_ADDR_RST;
      st_ff.nvm_addr <= qdu_pkg::NVM_ADDR_RST;
      st_ff.code <= {4{qdu_pkg::NVM_WORD_RST[11:0]}};
      st_ff.pd <= {4{qdu_pkg::NVM_WORD_RST[qdu_pkg::W_PD_LSB +: 2]}};
      st_ff.g2 <= {4{qdu_pkg::qdu_gain2(qdu_pkg::NVM_WORD_RST)}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; clock wire is never driven here
  assign dac_code = st_ff.code;
  assign powerdown_select = st_ff.pd;
  assign gain_x2 = st_ff.g2;
  assign nvm_busy = ~st_ff.rdy_oe_n;
  assign link.sda_dev_o = 1'h0;
  assign link.sda_dev_oe_n = st_ff.sda_oe_n;
  assign link.nvm_ready_busy_n_o = 1'h0;
  assign link.nvm_ready_busy_n_oe_n = st_ff.rdy_oe_n;
endmodule: qdu_dev

`default_nettype wire

// ---- qdu_hst.sv ----
// quad dac update control: controller end of the link
// assumes software on a plain strobe port, converter on the far side
`default_nettype none

module qdu_hst #(
  parameter int unsigned QTR_CYCLES = qdu_pkg::SCL_QTR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  qdu_link_if.hst link,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  typedef struct packed {
    logic [7:0] div;
    qdu_pkg::qdu_hst_state_t state;
    logic [1:0] ph;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [1:0] last_idx;
    logic rd_last;
    logic [3:0][7:0] bytes;
    logic [7:0] rx;
    logic nack;
    logic [1:0] sda_sy;
    logic [1:0] rdy_sy;
    logic scl_oe_n;
    logic sda_oe_n;
    logic strobe_n;
    logic [15:0] data;
    logic [31:0] rdata;
  } qdu_hst_st_t;

  qdu_hst_st_t st_ff;
  qdu_hst_st_t nxt_st;
  logic tick;
  logic rd_byte;

  assign tick = st_ff.div == 8'(QTR_CYCLES - 1);
  assign rd_byte = st_ff.rd_last && st_ff.byte_idx == st_ff.last_idx;

  ////////////////////////////////////////////////////////////////////////
  // next state: register port and bit engine
  always_comb begin
    logic [2:0] op;
    logic [2:0] tgt;
    op = reg_wdata[qdu_pkg::CTRL_OP_LSB +: 3];
    tgt = reg_wdata[qdu_pkg::CTRL_TGT_LSB +: 3];
    nxt_st = st_ff;
    nxt_st.sda_sy = {st_ff.sda_sy[0], link.sda};
    nxt_st.rdy_sy = {st_ff.rdy_sy[0], link.nvm_ready_busy_n};
    nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
    nxt_st.rdata = 32'h0000_0000;
    // register writes
    if (reg_wr) begin
      if (reg_addr == qdu_pkg::REG_DATA) begin
        nxt_st.data = reg_wdata[15:0];
      end else if (reg_addr == qdu_pkg::REG_STROBE) begin
        nxt_st.strobe_n = reg_wdata[0];
      end else if (reg_addr == qdu_pkg::REG_CTRL && st_ff.state == qdu_pkg::HST_IDLE &&
                   op <= qdu_pkg::OP_ADDR) begin
        nxt_st.bytes[0] = qdu_pkg::qdu_addr_byte(tgt, 1'h0);
        nxt_st.bytes[1] = {qdu_pkg::CMD_ADDR, reg_wdata[qdu_pkg::CTRL_NEW_LSB +: 3], 2'h0};
        nxt_st.bytes[2] = st_ff.data[15:8];
        nxt_st.bytes[3] = st_ff.data[7:0];
        nxt_st.last_idx = 2'h1;
        nxt_st.rd_last = 1'h0;
        if (op == qdu_pkg::OP_WRITE || op == qdu_pkg::OP_STORE) begin
          nxt_st.bytes[1] = {(op == qdu_pkg::OP_STORE) ? qdu_pkg::CMD_STORE : qdu_pkg::CMD_WRITE,
                             2'h0, reg_wdata[qdu_pkg::CTRL_CH_LSB +: 2],
                             reg_wdata[qdu_pkg::CTRL_UPD]};
          nxt_st.last_idx = 2'h3;
        end else if (op == qdu_pkg::OP_GCRESET) begin
          nxt_st.bytes[0] = qdu_pkg::GC_ADDR;
          nxt_st.bytes[1] = qdu_pkg::GC_RESET;
        end else if (op == qdu_pkg::OP_READ) begin
          nxt_st.bytes[0] = qdu_pkg::qdu_addr_byte(tgt, 1'h1);
          nxt_st.rd_last = 1'h1;
        end
        nxt_st.state = qdu_pkg::HST_START;
        nxt_st.ph = 2'h0;
        nxt_st.bit_cnt = 4'h0;
        nxt_st.byte_idx = 2'h0;
        nxt_st.nack = 1'h0;
      end
    end
    // register reads, data one cycle later
    if (reg_rd) begin
      if (reg_addr == qdu_pkg::REG_STATUS) begin
        nxt_st.rdata = {16'h0000, st_ff.rx, 5'h00, st_ff.rdy_sy[1], st_ff.nack,
                        st_ff.state != qdu_pkg::HST_IDLE};
      end else if (reg_addr == qdu_pkg::REG_DATA) begin
        nxt_st.rdata = {16'h0000, st_ff.data};
      end else if (reg_addr == qdu_pkg::REG_STROBE) begin
        nxt_st.rdata = {31'h0000_0000, st_ff.strobe_n};
      end
    end
    // quarter-period engine
    if (tick && st_ff.state != qdu_pkg::HST_IDLE) begin
      nxt_st.ph = st_ff.ph + 2'h1;
      unique case (st_ff.state)
        qdu_pkg::HST_START: begin
          if (st_ff.ph == 2'h0) begin
            nxt_st.sda_oe_n = 1'h0;
          end else begin
            nxt_st.scl_oe_n = 1'h0;
            nxt_st.state = qdu_pkg::HST_BIT;
            nxt_st.ph = 2'h0;
          end
        end
        qdu_pkg::HST_BIT: begin
          unique case (st_ff.ph)
            2'h0: begin
              nxt_st.sda_oe_n = (st_ff.bit_cnt[3] || rd_byte) ? 1'h1 :
                                st_ff.bytes[st_ff.byte_idx][~st_ff.bit_cnt[2:0]];
            end
            2'h1: nxt_st.scl_oe_n = 1'h1;
            2'h2: begin
              if (!st_ff.bit_cnt[3] && rd_byte) begin
                nxt_st.rx = {st_ff.rx[6:0], st_ff.sda_sy[1]};
              end else if (st_ff.bit_cnt[3] && !rd_byte && st_ff.sda_sy[1]) begin
                nxt_st.nack = 1'h1;
              end
            end
            2'h3: begin
              nxt_st.scl_oe_n = 1'h0;
              nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
              if (st_ff.bit_cnt[3]) begin
                nxt_st.bit_cnt = 4'h0;
                nxt_st.byte_idx = st_ff.byte_idx + 2'h1;
                if (st_ff.byte_idx == st_ff.last_idx || st_ff.nack) begin
                  nxt_st.state = qdu_pkg::HST_STOP;
                end
              end
            end
          endcase
        end
        qdu_pkg::HST_STOP: begin
          unique case (st_ff.ph)
            2'h0: nxt_st.sda_oe_n = 1'h0;
            2'h1: nxt_st.scl_oe_n = 1'h1;
            2'h2: nxt_st.sda_oe_n = 1'h1;
            2'h3: nxt_st.state = qdu_pkg::HST_IDLE;
          endcase
        end
        default: nxt_st.state = qdu_pkg::HST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.state <= qdu_pkg::HST_IDLE;
      st_ff.sda_sy <= 2'h3;
      st_ff.rdy_sy <= 2'h3;
      st_ff.scl_oe_n <= 1'h1;
      st_ff.sda_oe_n <= 1'h1;
      st_ff.strobe_n <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata = st_ff.rdata;
  assign link.scl_o = 1'h0;
  assign link.scl_oe_n = st_ff.scl_oe_n;
  assign link.sda_hst_o = 1'h0;
  assign link.sda_hst_oe_n = st_ff.sda_oe_n;
  assign link.output_load_strobe_n = st_ff.strobe_n;
endmodule: qdu_hst

`default_nettype wire

// ---- qdu_link_monitor.sv ----
// quad dac update control: checker on the link wires
// assumes the enables and wired levels of one controller/converter link
`default_nettype none

module qdu_link_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_oe_n,
  input wire logic sda_dev_oe_n,
  input wire logic output_load_strobe_n,
  input wire logic nvm_ready_busy_n_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int REL_MIN = 2;
  localparam int REL_MAX = 6;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // clock wire belongs to the controller alone
  chk_clk_host_only: assert property (!scl |-> !scl_oe_n)
    else $error("clock low without controller drive");
  chk_clk_follows_host: assert property ($changed(scl) |-> $changed(scl_oe_n))
    else $error("clock moved without controller");
  // converter data moves only while clock low, held through high
  chk_dev_data_low: assert property ($changed(sda_dev_oe_n) |-> !scl && !$past(scl))
    else $error("converter data changed with clock high");
  chk_dev_ack_hold: assert property ($rose(scl) && !sda_dev_oe_n |-> (!sda_dev_oe_n)[*3])
    else $error("converter data not held while clock high");
  chk_dev_data_bound: assert property (!sda_dev_oe_n |-> ##[1:80] sda_dev_oe_n)
    else $error("converter holds data line too long");
  chk_data_wired: assert property (!sda_dev_oe_n |-> !sda)
    else $error("data wire not pulled low");
  // busy line: starts on an idle bus, lasts the programming time
  chk_busy_at_stop: assert property ($fell(nvm_ready_busy_n_oe_n) |-> scl && sda)
    else $error("busy started inside a frame");
  chk_busy_span: assert property ($fell(nvm_ready_busy_n_oe_n) |->
      (!nvm_ready_busy_n_oe_n)[*8] ##1 (!nvm_ready_busy_n_oe_n)[*8]
      ##[REL_MIN:REL_MAX] nvm_ready_busy_n_oe_n)
    else $error("busy length wrong");

  // main scenarios reached
  cov_strobe_fall: cover property ($fell(output_load_strobe_n));
  cov_dev_ack: cover property ($rose(scl) && !sda_dev_oe_n);
  cov_busy: cover property ($rose(nvm_ready_busy_n_oe_n));
endmodule: qdu_link_monitor

`default_nettype wire

// ---- test_quad_dac_update_control.sv ----
// quad dac update control: both link ends driven through the register port
// assumes qdu_pkg, qdu_link_if, qdu_hst, qdu_dev and the link monitor
`default_nettype none

module test_quad_dac_update_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk;
  logic nrst;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0][11:0] dac_code;
  logic [3:0][1:0] powerdown_select;
  logic [3:0] gain_x2;
  logic nvm_busy;
  logic [15:0] exp_word [4];
  logic [31:0] s;
  int mismatches;
  int checks_done;
  int n;

  ////////////////////////////////////////////////////////////////////////////////
  // both ends across one link, checker beside it
  qdu_link_if qdu_link_if_inst ();
  qdu_hst #(.QTR_CYCLES(2)) qdu_hst_inst (.sys_clk(sys_clk), .nrst(nrst),
    .link(qdu_link_if_inst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  qdu_dev #(.PROG_CYCLES(20)) qdu_dev_inst (.sys_clk(sys_clk), .nrst(nrst),
    .link(qdu_link_if_inst), .dac_code(dac_code), .powerdown_select(powerdown_select),
    .gain_x2(gain_x2), .nvm_busy(nvm_busy));
  qdu_link_monitor qdu_link_monitor_inst (.sys_clk(sys_clk), .nrst(nrst),
    .scl_oe_n(qdu_link_if_inst.scl_oe_n), .sda_dev_oe_n(qdu_link_if_inst.sda_dev_oe_n),
    .output_load_strobe_n(qdu_link_if_inst.output_load_strobe_n),
    .nvm_ready_busy_n_oe_n(qdu_link_if_inst.nvm_ready_busy_n_oe_n),
    .scl(qdu_link_if_inst.scl), .sda(qdu_link_if_inst.sda));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, compare and register port tasks
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask: end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask: cmp

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask: wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask: rd

  // load data word, start one engine operation, poll until idle
  task automatic op(input logic [2:0] o, input logic [1:0] ch, input logic upd,
      input logic [15:0] d);
    logic [31:0] st;
    int k;
    wr(qdu_pkg::REG_DATA, {16'h0000, d});
    wr(qdu_pkg::REG_CTRL, 32'(o) | (32'(ch) << 3) | (32'(upd) << 5));
    st = 32'h0000_0001;
    k = 0;
    while (st[0] !== 1'b0 && k < 600) begin
      rd(qdu_pkg::REG_STATUS, st);
      k++;
    end
    cmp(32'(st[0]), 32'h0000_0000);
  endtask: op

  // every channel output against the expected output word
  task automatic chk_all();
    #1;
    for (int i = 0; i < 4; i++) begin
      cmp(32'(dac_code[i]), 32'(exp_word[i][11:0]));
      cmp(32'(powerdown_select[i]), 32'(exp_word[i][14:13]));
      cmp(32'(gain_x2[i]), 32'(exp_word[i][15] & exp_word[i][12]));
    end
  endtask: chk_all

  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    #(40000 * 50);
    mismatches++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    checks_done = 0;
    for (int i = 0; i < 4; i++) exp_word[i] = 16'h8000;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_all();
    rd(4'h2, s);
    cmp(s, 32'h0000_0000);
    // strobe high, update bit set: inputs only
    op(qdu_pkg::OP_WRITE, 2'h0, 1'b1, 16'h0abc);
    op(qdu_pkg::OP_WRITE, 2'h2, 1'b1, 16'h9123);
    chk_all();
    wr(qdu_pkg::REG_STROBE, 32'h0000_0000);
    repeat (5) @(posedge sys_clk);
    exp_word[0] = 16'h0abc;
    exp_word[2] = 16'h9123;
    chk_all();
    // strobe held low: update at last ack
    op(qdu_pkg::OP_WRITE, 2'h3, 1'b1, 16'h1555);
    exp_word[3] = 16'h1555;
    chk_all();
    wr(qdu_pkg::REG_STROBE, 32'h0000_0001);
    // update bit per channel, every power-down code, both references
    for (int i = 0; i < 4; i++) begin
      exp_word[i] = {i[0], i[1:0], 1'b1, 12'h3c0 | 12'(i)};
      op(qdu_pkg::OP_WRITE, 2'(i), 1'b0, exp_word[i]);
      chk_all();
    end
    // store then watch the busy line
    op(qdu_pkg::OP_STORE, 2'h1, 1'b1, 16'h8fff);
    chk_all();
    n = 0;
    while (nvm_busy !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    cmp(32'(qdu_link_if_inst.nvm_ready_busy_n), 32'h0000_0000);
    cmp(32'(nvm_busy), 32'h0000_0001);
    repeat (40) @(posedge sys_clk);
    cmp(32'(qdu_link_if_inst.nvm_ready_busy_n), 32'h0000_0001);
    cmp(32'(nvm_busy), 32'h0000_0000);
    // general call reset reloads stored words
    op(qdu_pkg::OP_GCRESET, 2'h0, 1'b1, 16'h0000);
    for (int i = 0; i < 4; i++) exp_word[i] = (i == 1) ? 16'h8fff : 16'h8000;
    chk_all();
    // status byte read back over the link
    op(qdu_pkg::OP_READ, 2'h0, 1'b1, 16'h0000);
    rd(qdu_pkg::REG_STATUS, s);
    cmp(32'(s[15:8]), 32'h0000_0080);
    // address write refused while strobe high
    op(qdu_pkg::OP_ADDR, 2'h0, 1'b1, 16'h0000);
    rd(qdu_pkg::REG_STATUS, s);
    cmp(32'(s[1]), 32'h0000_0001);
    cmp(32'(s[2]), 32'h0000_0001);
    // address write taken with strobe low, starts programming
    wr(qdu_pkg::REG_STROBE, 32'h0000_0000);
    op(qdu_pkg::OP_ADDR, 2'h0, 1'b1, 16'h0000);
    rd(qdu_pkg::REG_STATUS, s);
    cmp(32'(s[1]), 32'h0000_0000);
    cmp(32'(s[2]), 32'h0000_0000);
    end_sim();
  end
endmodule: test_quad_dac_update_control

`default_nettype wire
